// ### logic/ldsl_device.sv
`timescale 1ns/1ns
module ldsl_device (
   input wire logic clk_sys,
   input wire logic rst_n,
   ldsl_if.dev link,
   output logic [16:0] dac_code,
   output logic alarm_mode,
   output logic load_done
);
   import ldsl_pkg::*;

   // ****************
   // Pin synchronisers
   // ****************
   // Reset to idle levels, so no false strobe edge follows reset
   logic [LDSL_PIN_COUNT-1:0] pin_raw;
   wire [LDSL_PIN_COUNT-1:0] pin_sync;
   wire [LDSL_PIN_COUNT-1:0] pin_hist;

   assign pin_raw[LDSL_PIN_SCLK] = link.sclk;
   assign pin_raw[LDSL_PIN_DATA] = link.sdata;
   assign pin_raw[LDSL_PIN_LOAD] = link.load;

   genvar pin_idx;
   generate
      for (pin_idx = 0; pin_idx < LDSL_PIN_COUNT; pin_idx++) begin : g_pin_sync
         logic meta_q;
         logic meta_d;
         logic sync_q;
         logic sync_d;
         logic hist_q;
         logic hist_d;

         always_comb begin
            meta_d = pin_raw[pin_idx];
            sync_d = meta_q;
            hist_d = sync_q;
         end

         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               meta_q <= LDSL_PIN_IDLE[pin_idx];
               sync_q <= LDSL_PIN_IDLE[pin_idx];
               hist_q <= LDSL_PIN_IDLE[pin_idx];
            end else begin
               meta_q <= meta_d;
               sync_q <= sync_d;
               hist_q <= hist_d;
            end
         end

         assign pin_sync[pin_idx] = sync_q;
         assign pin_hist[pin_idx] = hist_q;
      end
   endgenerate

   // ****************
   // Edge detection
   // ****************
   logic sclk_now;
   logic sclk_prev;
   logic load_now;
   logic load_prev;
   logic data_bit;
   logic clk_rise;
   logic load_rise;

   assign sclk_now = pin_sync[LDSL_PIN_SCLK];
   assign sclk_prev = pin_hist[LDSL_PIN_SCLK];
   assign load_now = pin_sync[LDSL_PIN_LOAD];
   assign load_prev = pin_hist[LDSL_PIN_LOAD];
   // Data rides the same pipeline as the clock, so both line up
   assign data_bit = pin_sync[LDSL_PIN_DATA];
   assign clk_rise = sclk_now & ~sclk_prev;
   assign load_rise = load_now & ~load_prev;

   // ****************
   // Input shift register
   // ****************
   logic [LDSL_ALARM_BITS-1:0] sh_q;
   logic [LDSL_ALARM_BITS-1:0] sh_d;

   always_comb begin
      sh_d = sh_q;
      // A clock edge in the strobe cycle is dropped
      if (clk_rise && !load_rise) begin
         sh_d = {sh_q[LDSL_ALARM_BITS-2:0], data_bit};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= LDSL_CODE_RESET;
      end else begin
         sh_q <= sh_d;
      end
   end

   // ****************
   // Edge counter
   // ****************
   logic [LDSL_CNT_BITS-1:0] cnt_q;
   logic [LDSL_CNT_BITS-1:0] cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      if (load_rise) begin
         cnt_d = '0;
      end else if (clk_rise) begin
         // Wraps at 32 on its own width
         cnt_d = cnt_q + LDSL_CNT_BITS'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // ****************
   // Mode classification
   // ****************
   logic period_alarm;
   logic [LDSL_ALARM_BITS-1:0] word_sel;

   always_comb begin
      // Count is taken before the strobe clears it
      period_alarm = (cnt_q > LDSL_NORM_MAX);
      word_sel = {1'b0, sh_q[LDSL_NORM_BITS-1:0]};
      if (period_alarm) begin
         // Earlier bits have already left the register
         word_sel = sh_q;
      end
   end

   // ****************
   // Converter latch
   // ****************
   logic [LDSL_ALARM_BITS-1:0] code_q;
   logic [LDSL_ALARM_BITS-1:0] code_d;

   always_comb begin
      code_d = code_q;
      if (load_rise) begin
         code_d = word_sel;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         code_q <= LDSL_CODE_RESET;
      end else begin
         code_q <= code_d;
      end
   end

   // ****************
   // Mode flag
   // ****************
   logic alarm_q;
   logic alarm_d;

   always_comb begin
      alarm_d = alarm_q;
      if (load_rise) begin
         if (period_alarm) begin
            alarm_d = 1'b1;
         end else begin
            alarm_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         alarm_q <= 1'b0;
      end else begin
         alarm_q <= alarm_d;
      end
   end

   // ****************
   // Load pulse
   // ****************
   logic done_q;
   logic done_d;

   always_comb begin
      done_d = load_rise;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         done_q <= 1'b0;
      end else begin
         done_q <= done_d;
      end
   end

   // ****************
   // Outputs
   // ****************
   // Code 0x10000 in alarm mode means 16 mA; analog side scales
   assign dac_code = code_q;
   assign alarm_mode = alarm_q;
   assign load_done = done_q;
endmodule // ldsl_device

// ### logic/ldsl_pkg.sv
package ldsl_pkg;
   // ****************
   // Link constants
   // ****************
   localparam int LDSL_NORM_BITS = 16;
   localparam int LDSL_ALARM_BITS = 17;
   localparam int LDSL_CNT_BITS = 5;
   localparam int LDSL_BYTE_BITS = 8;
   localparam logic [4:0] LDSL_NORM_MAX = 5'h10;
   localparam logic [16:0] LDSL_CODE_RESET = 17'h0_0000;
   localparam logic [16:0] LDSL_ALARM_LO = 17'h0_3800;
   localparam logic [16:0] LDSL_ALARM_HI = 17'h1_8000;
   localparam int LDSL_SCLK_DIV = 4;
   localparam int LDSL_PIN_COUNT = 3;
   localparam int LDSL_PIN_SCLK = 2;
   localparam int LDSL_PIN_DATA = 1;
   localparam int LDSL_PIN_LOAD = 0;
   localparam logic [2:0] LDSL_PIN_IDLE = 3'h1;
endpackage

// ### logic/ldsl_if.sv
`timescale 1ns/1ns
interface ldsl_if;
   logic sclk;
   logic sdata;
   logic load;
   modport dev (input sclk, input sdata, input load);
   modport host (output sclk, output sdata, output load);
endinterface

// ### logic/ldsl_host.sv
`timescale 1ns/1ns
module ldsl_host (
   input wire logic clk_sys,
   input wire logic rst_n,
   ldsl_if.host link,
   input wire logic wr_valid,
   input wire logic wr_alarm,
   input wire logic [16:0] wr_code,
   output logic wr_ready
);
   import ldsl_pkg::*;
   typedef enum logic [1:0] {LDSL_IDLE, LDSL_LOW, LDSL_HIGH, LDSL_LATCH} ldsl_state_t;
   ldsl_state_t st_q, st_d;
   logic [23:0] sh_q, sh_d;
   logic [4:0] bits_q, bits_d;
   logic [2:0] div_q, div_d;
   logic sclk_q, sclk_d, load_q, load_d;
   logic [16:0] clamp;
   always_comb begin
      // Out-of-range alarm codes give no defined current
      clamp = wr_code;
      if (wr_code < LDSL_ALARM_LO) clamp = LDSL_ALARM_LO;
      if (wr_code > LDSL_ALARM_HI) clamp = LDSL_ALARM_HI;
   end
   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      bits_d = bits_q;
      div_d = div_q + 3'h1;
      sclk_d = sclk_q;
      load_d = load_q;
      unique case (st_q)
         LDSL_IDLE: begin
            div_d = '0;
            sclk_d = 1'b0;
            if (wr_valid) begin
               load_d = 1'b0;
               st_d = LDSL_LOW;
               if (wr_alarm) begin
                  sh_d = {7'h00, clamp};
                  bits_d = 5'(3 * LDSL_BYTE_BITS);
               end else begin
                  sh_d = {wr_code[15:0], 8'h00};
                  bits_d = 5'(LDSL_NORM_BITS);
               end
            end
         end
         LDSL_LOW: if (div_q == 3'(LDSL_SCLK_DIV - 1)) begin
            div_d = '0;
            sclk_d = 1'b1;
            st_d = LDSL_HIGH;
         end
         LDSL_HIGH: if (div_q == 3'(LDSL_SCLK_DIV - 1)) begin
            div_d = '0;
            sclk_d = 1'b0;
            sh_d = {sh_q[22:0], 1'b0};
            bits_d = bits_q - 5'h1;
            st_d = (bits_q == 5'h1) ? LDSL_LATCH : LDSL_LOW;
         end
         LDSL_LATCH: if (div_q == 3'(LDSL_SCLK_DIV - 1)) begin
            load_d = 1'b1;
            st_d = LDSL_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= LDSL_IDLE;
         sh_q <= 24'h00_0000;
         bits_q <= 5'h0;
         div_q <= 3'h0;
         sclk_q <= 1'b0;
         load_q <= 1'b1;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         bits_q <= bits_d;
         div_q <= div_d;
         sclk_q <= sclk_d;
         load_q <= load_d;
      end
   end
   // No isolator inversion in this path
   assign link.sclk = sclk_q;
   assign link.sdata = sh_q[23];
   assign link.load = load_q;
   assign wr_ready = (st_q == LDSL_IDLE);
endmodule // ldsl_host

// ### test/ldsl_link_monitor.sv
`timescale 1ns/1ns
module ldsl_link_monitor (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic load,
   input wire logic [16:0] dac_code,
   input wire logic alarm_mode,
   input wire logic load_done
);
   import ldsl_pkg::*;
   // ***
   // Link checks
   // ***
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_done;
      ##[3:4] load_done;
   endsequence
   sequence s_high;
      sclk [*4] ##1 !sclk;
   endsequence
   AST_LOAD_DONE: assert property ($rose(load) |-> s_done) else $error("no load pulse");
   AST_SCLK_PH: assert property ($rose(sclk) |-> s_high) else $error("bad sclk phase");
   AST_IDLE_LO: assert property (load |-> !sclk) else $error("sclk not idle low");
   AST_FRAME: assert property ($fell(load) |-> !load [*8]) else $error("short frame");
   AST_HOLD: assert property (!load_done |-> $stable(dac_code)) else $error("latch moved");
   AST_PULSE: assert property (load_done |=> !load_done) else $error("long pulse");
   AST_NORM: assert property (load_done && !alarm_mode |-> !dac_code[16]) else $error("bit16 set");
   AST_RANGE: assert property (load_done && alarm_mode |-> dac_code inside {[LDSL_ALARM_LO:LDSL_ALARM_HI]})
      else $error("alarm out of range");
endmodule // ldsl_link_monitor

// ### test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import ldsl_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic wr_valid = 1'b0;
   logic wr_alarm = 1'b0;
   logic [16:0] wr_code = 17'h0_0000;
   logic wr_ready;
   logic alarm_mode;
   logic load_done;
   logic [16:0] dac_code;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;
   ldsl_if ldsl_if_i ();
   ldsl_device ldsl_device_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(ldsl_if_i), .dac_code(dac_code),
      .alarm_mode(alarm_mode), .load_done(load_done));
   ldsl_host ldsl_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(ldsl_if_i), .wr_valid(wr_valid),
      .wr_alarm(wr_alarm), .wr_code(wr_code), .wr_ready(wr_ready));
   ldsl_link_monitor ldsl_link_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(ldsl_if_i.sclk),
      .load(ldsl_if_i.load), .dac_code(dac_code), .alarm_mode(alarm_mode), .load_done(load_done));
   always #4 clk_sys = ~clk_sys;
   // Budget nearly four times the expected run
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total++;
         summarize();
      end
   end
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic send(input logic alm, input logic [16:0] code, input logic [16:0] exp);
      @(posedge clk_sys);
      #1;
      wr_valid = 1'b1;
      wr_alarm = alm;
      wr_code = code;
      @(posedge clk_sys);
      #1;
      wr_valid = 1'b0;
      chk({16'h0000, wr_ready}, 17'h0_0000);
      while (load_done !== 1'b1) begin
         @(posedge clk_sys);
         #1;
      end
      chk(dac_code, exp);
      chk({16'h0000, alarm_mode}, {16'h0000, alm});
      chk({16'h0000, wr_ready}, 17'h0_0001);
   endtask
   task automatic t_alarm();
      send(1'b1, 17'h1_0000, 17'h1_0000);
      send(1'b1, 17'h0_4000, 17'h0_4000);
      send(1'b1, 17'h1_8000, 17'h1_8000);
      send(1'b1, 17'h0_3C00, 17'h0_3C00);
   endtask
   task automatic t_clamp();
      send(1'b1, 17'h1_FFFF, LDSL_ALARM_HI);
      send(1'b1, 17'h0_0001, LDSL_ALARM_LO);
   endtask
   // Normal last, so mode falls back per period
   task automatic t_normal();
      send(1'b0, 17'h0_FFFF, 17'h0_FFFF);
      send(1'b0, 17'h0_0000, 17'h0_0000);
      send(1'b0, 17'h1_A5C3, 17'h0_A5C3);
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      t_alarm();
      t_clamp();
      t_normal();
      summarize();
   end
endmodule // tb_top
